/* File: bench/battery_backed_sram_with_rtc_bytes_tb.sv */
module battery_backed_sram_with_rtc_bytes_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        powerGood = 1'b1;
    logic        batteryMode = 1'b0;
    logic        chipSel_n, outDrive_n, storeStrobe_n, hostOe, dataLinesOe, eOe;
    logic [14:0] byteAddress;
    logic [7:0]  hostData, dataLinesIn, dataLinesOut, eV, fV;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;

    // --------------------------------------------------------
    // Clock, watchdog and shared data wire
    // --------------------------------------------------------
    always #12.5 core_clk = ~core_clk;

    // Cuts a hang short; the whole run needs about 500 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            results();
        end
    end

    // Released wire shows the inverse of the last host value
    assign dataLinesIn = dataLinesOe ? dataLinesOut : (hostOe ? hostData : ~hostData);

    bbs_host_model host (
        .core_clk(core_clk), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
        .chipSel_n(chipSel_n), .outDrive_n(outDrive_n), .storeStrobe_n(storeStrobe_n),
        .byteAddress(byteAddress), .hostData(hostData), .hostOe(hostOe));

    bbs_sram_rtc #(.REC_CYC(20), .SEC_CYC(50)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .chipSel_n(chipSel_n),
        .outDrive_n(outDrive_n), .storeStrobe_n(storeStrobe_n),
        .byteAddress(byteAddress), .dataLinesIn(dataLinesIn),
        .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
        .powerGood(powerGood), .batteryMode(batteryMode));

    // --------------------------------------------------------
    // Checks and verdict
    // --------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] expv, input logic [7:0] got);
        total_checks++;
        if (got !== expv)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic rdchk(input logic [14:0] a, input logic [7:0] expv, input logic expOe);
        host.rd(a, 1'b0, eV, fV, eOe);
        chk("oe", {7'h0, expOe}, {7'h0, eOe});
        if (expOe)
            chk("data", expv, fV);
    endtask

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        repeat (40) @(posedge core_clk);
        host.wr(15'h0000, 8'h11);
        host.wr(15'h1555, 8'h5A);
        host.wr(15'h7FF7, 8'hC3);
        host.wr(15'h0100, 8'h3C, 1'b0);
        rdchk(15'h0000, 8'h11, 1'b1);
        chk("early", 8'hA5, eV);
        rdchk(15'h1555, 8'h5A, 1'b1);
        rdchk(15'h7FF7, 8'hC3, 1'b1);
        rdchk(15'h0100, 8'h3C, 1'b1);
        host.rd(15'h0000, 1'b1, eV, fV, eOe);
        chk("oe drive high", 8'h00, {7'h0, eOe});
        $display("test memory done");
        #2;
        powerGood = 1'b0;
        batteryMode = 1'b1;
        repeat (4) @(posedge core_clk);
        host.wr(15'h0000, 8'hFF);
        rdchk(15'h0000, 8'h00, 1'b0);
        #2;
        powerGood = 1'b1;
        batteryMode = 1'b0;
        repeat (3) @(posedge core_clk);
        rdchk(15'h0000, 8'h00, 1'b0);
        repeat (30) @(posedge core_clk);
        rdchk(15'h0000, 8'h11, 1'b1);
        rdchk(15'h1555, 8'h5A, 1'b1);
        $display("test power done");
        host.wr(15'h7FF8, 8'h8A);
        rdchk(15'h7FF8, 8'h8A, 1'b1);
        host.wr(15'h7FF9, 8'h59);
        host.wr(15'h7FFA, 8'h59);
        host.wr(15'h7FFB, 8'h23);
        host.wr(15'h7FFD, 8'h28);
        host.wr(15'h7FFE, 8'h02);
        host.wr(15'h7FFF, 8'h23);
        host.wr(15'h7FF8, 8'h0A);
        repeat (60) @(posedge core_clk);
        rdchk(15'h7FFB, 8'h00, 1'b1);
        rdchk(15'h7FFA, 8'h00, 1'b1);
        rdchk(15'h7FFD, 8'h01, 1'b1);
        rdchk(15'h7FFE, 8'h03, 1'b1);
        rdchk(15'h7FF8, 8'h0A, 1'b1);
        $display("test clock done");
        results();
    end
endmodule // battery_backed_sram_with_rtc_bytes_tb

/* File: bench/bbs_host_model.sv */
module bbs_host_model (
    input  wire logic        core_clk,      // Core clock
    input  wire logic [7:0]  dataLinesOut,  // Device read data
    input  wire logic        dataLinesOe,   // Device drives lines
    output logic             chipSel_n,     // Chip select
    output logic             outDrive_n,    // Output drive
    output logic             storeStrobe_n, // Store strobe
    output logic [14:0]      byteAddress,   // Byte address
    output logic [7:0]       hostData,      // Host write data
    output logic             hostOe         // Host drives lines
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        chipSel_n = 1'b1;
        outDrive_n = 1'b1;
        storeStrobe_n = 1'b1;
        byteAddress = 15'h0000;
        hostData = 8'h00;
        hostOe = 1'b0;
    end

    // Write: drive normally high; a low drive exercises the strobe float
    task automatic wr(input logic [14:0] a, input logic [7:0] d,
                      input logic drvN = 1'b1);
        @(posedge core_clk);
        #2;
        outDrive_n = drvN;
        byteAddress = a;
        hostData = d;
        hostOe = 1'b1;
        chipSel_n = 1'b0;
        storeStrobe_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #2;
        storeStrobe_n = 1'b1;
        chipSel_n = 1'b1;
        outDrive_n = 1'b1;
        repeat (2) @(posedge core_clk);
        #2;
        hostOe = 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    // Read: early sample lands before the address delay is over
    task automatic rd(input logic [14:0] a, input logic drvN,
                      output logic [7:0] early, output logic [7:0] fin,
                      output logic finOe);
        @(posedge core_clk);
        #2;
        byteAddress = a;
        outDrive_n = drvN;
        chipSel_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        early = dataLinesOut;
        repeat (4) @(posedge core_clk);
        #1;
        fin = dataLinesOut;
        finOe = dataLinesOe;
        @(posedge core_clk);
        #2;
        chipSel_n = 1'b1;
        outDrive_n = 1'b1;
        repeat (3) @(posedge core_clk);
    endtask
endmodule // bbs_host_model

/* File: rtl/bbs_bcd_count.sv */
`include "bbs_defs.svh"

module bbs_bcd_count #(
    parameter logic [7:0] MIN_VAL = 8'h00
)(
    input  wire logic       core_clk, // Core clock
    input  wire logic       rst_n,    // Async reset
    input  wire logic       step,     // Advance by one
    input  wire logic       load,     // Load from loadVal
    input  wire logic [7:0] loadVal,  // BCD value to load
    input  wire logic [7:0] maxVal,   // Last value before wrap
    output logic      [7:0] count_q,  // BCD count
    output logic            wrap      // Wraps this cycle
);

    logic [7:0] count_d;

    // Out-of-range values written by the host also wrap to MIN_VAL
    assign wrap = step & ~load & (count_q >= maxVal);

    // Next BCD value
    always_comb
    begin
        count_d = count_q;
        if (load)
            count_d = loadVal;
        else if (wrap)
            count_d = MIN_VAL;
        else if (step && count_q[3:0] == 4'h9)
            count_d = {count_q[7:4] + 4'h1, 4'h0};
        else if (step)
            count_d = count_q + 8'h01;
    end

    // Register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= MIN_VAL;
        else
            count_q <= count_d;
    end

endmodule // bbs_bcd_count

/* File: rtl/bbs_defs.svh */
`ifndef BBS_DEFS_SVH
`define BBS_DEFS_SVH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define BBS_ADDR_W      15
`define BBS_MEM_DEPTH   32768
`define BBS_RTC_BASE    15'h7FF8
`define BBS_CTRL_IDX    3'h0
`define BBS_SEC_IDX     3'h1
`define BBS_MIN_IDX     3'h2
`define BBS_HOUR_IDX    3'h3
`define BBS_DAY_IDX     3'h4
`define BBS_DATE_IDX    3'h5
`define BBS_MON_IDX     3'h6
`define BBS_YEAR_IDX    3'h7

// ----------------------------------------------------------------
// Control byte fields, reset values and undefined read data
// ----------------------------------------------------------------
`define BBS_CTL_WRITE   7
`define BBS_CTL_READ    6
`define BBS_CTL_CAL_HI  4
`define BBS_CTL_RST     8'h00
`define BBS_UNDEF_DATA  8'hA5

// ----------------------------------------------------------------
// Timing, in ns or ms as printed, and derived cycle counts
// ----------------------------------------------------------------
`define BBS_CLK_NS      25
`define BBS_T_ADDR_NS   70
`define BBS_T_SEL_NS    70
`define BBS_T_DRV_NS    35
`define BBS_T_HOLD_NS   10
`define BBS_T_FLOAT_NS  25
`define BBS_T_REC_MS    40
`define BBS_T_SEC_NS    1000000000
`define BBS_ADDR_CYC  ((`BBS_T_ADDR_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_SEL_CYC   ((`BBS_T_SEL_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_DRV_CYC   ((`BBS_T_DRV_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_HOLD_CYC  ((`BBS_T_HOLD_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_FLOAT_CYC (`BBS_T_FLOAT_NS / `BBS_CLK_NS)
`define BBS_REC_CYC   (`BBS_T_REC_MS * 1000000 / `BBS_CLK_NS)
`define BBS_SEC_CYC   (`BBS_T_SEC_NS / `BBS_CLK_NS)

`endif

/* File: rtl/bbs_pkg.sv */
package bbs_pkg;

    // ------------------------------------------------------------
    // Bus pins as sampled
    // ------------------------------------------------------------
    typedef struct packed {
        logic        sel_n;
        logic        drv_n;
        logic        stb_n;
        logic [14:0] addr;
        logic [7:0]  data;
    } bbs_pins_type;

    // ------------------------------------------------------------
    // Supply state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PWR_OFF = 3'h1,
        PWR_REC = 3'h2,
        PWR_ON  = 3'h4
    } bbs_pwr_type;

endpackage

/* File: rtl/bbs_sram_rtc.sv */
// Overview of operation
// - A 15-bit address selects one of 32,768 bytes per access.
// - Read mode while select low and store strobe high.
// - Read data valid only after address, select and drive delays all pass.
// - Data lines driven only while select and drive are both low.
// - Outputs enabled before the address delay show undefined data.
// - On address change old data holds, then undefined until new access.
// - Write mode while store strobe and select are both low.
// - Write starts at later falling edge, ends at earlier rising edge.
// - Falling strobe during an active read floats outputs after a delay.
// - The top eight bytes hold clock data, not plain storage.
// - Clock bytes hold BCD year to second, 24-hour hours.
// - Calendar rolls over at 28, 29, 30 and 31 day month ends.
// - Lowest clock byte is control: gates clock access, holds calibration.
// - Clock bytes are separate cells, refreshed from counters every second.
// - Clock bytes use the same bus protocol as other memory.
// - Supply out of tolerance: writes blocked, inputs ignored, lines float.
// - On battery, memory and clock counting keep running.
// - After supply returns, inputs stay ignored for a recovery time.
`include "bbs_defs.svh"

module bbs_sram_rtc #(
    parameter int REC_CYC = `BBS_REC_CYC, // Power-up recovery cycles
    parameter int SEC_CYC = `BBS_SEC_CYC  // Cycles per second
)(
    input  wire logic        core_clk,      // 40 MHz clock
    input  wire logic        rst_n,         // Async reset
    input  wire logic        chipSel_n,     // Chip select
    input  wire logic        outDrive_n,    // Output drive
    input  wire logic        storeStrobe_n, // Store strobe
    input  wire logic [14:0] byteAddress,   // Byte address
    input  wire logic [7:0]  dataLinesIn,   // Data lines, in
    output logic      [7:0]  dataLinesOut,  // Data lines, out
    output logic             dataLinesOe,   // Data lines driven
    input  wire logic        powerGood,     // Supply in tolerance
    input  wire logic        batteryMode    // Below switchover level
);

    localparam int ADDR_CYC  = `BBS_ADDR_CYC;
    localparam int SEL_CYC   = `BBS_SEL_CYC;
    localparam int DRV_CYC   = `BBS_DRV_CYC;
    localparam int HOLD_CYC  = `BBS_HOLD_CYC;
    localparam int FLOAT_CYC = `BBS_FLOAT_CYC;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    bbs_pkg::bbs_pins_type pinsMeta_q;
    bbs_pkg::bbs_pins_type pinsSync_q;
    bbs_pkg::bbs_pins_type pinsRaw;
    logic [1:0]            pwrMeta_q;
    logic [1:0]            pwrSync_q;

    assign pinsRaw = '{chipSel_n, outDrive_n, storeStrobe_n,
                       byteAddress, dataLinesIn};

    // All pins pass two flops; idle pin state is deselected
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinsMeta_q <= '{1'b1, 1'b1, 1'b1, 15'h0000, 8'h00};
            pinsSync_q <= '{1'b1, 1'b1, 1'b1, 15'h0000, 8'h00};
            pwrMeta_q  <= 2'h0;
            pwrSync_q  <= 2'h0;
        end
        else
        begin
            pinsMeta_q <= pinsRaw;
            pinsSync_q <= pinsMeta_q;
            pwrMeta_q  <= {powerGood, batteryMode};
            pwrSync_q  <= pwrMeta_q;
        end
    end

    // ------------------------------------------------------------
    // Supply state
    // ------------------------------------------------------------
    bbs_pkg::bbs_pwr_type pwrState_q;
    bbs_pkg::bbs_pwr_type pwrState_d;
    logic [31:0]          recCnt_q;
    logic [31:0]          recCnt_d;
    logic                 supplyOk;
    logic                 busOn;

    assign supplyOk = pwrSync_q[1] & ~pwrSync_q[0];
    assign busOn    = (pwrState_q == bbs_pkg::PWR_ON) & supplyOk;

    // A supply dip restarts the whole recovery wait
    always_comb
    begin
        pwrState_d = pwrState_q;
        recCnt_d   = 32'h0000_0000;
        unique case (pwrState_q)
            bbs_pkg::PWR_OFF:
                if (supplyOk)
                    pwrState_d = bbs_pkg::PWR_REC;
            bbs_pkg::PWR_REC:
                if (!supplyOk)
                    pwrState_d = bbs_pkg::PWR_OFF;
                else if (recCnt_q >= 32'(REC_CYC - 1))
                    pwrState_d = bbs_pkg::PWR_ON;
                else
                    recCnt_d = recCnt_q + 32'h0000_0001;
            bbs_pkg::PWR_ON:
                if (!supplyOk)
                    pwrState_d = bbs_pkg::PWR_OFF;
            default:
                pwrState_d = bbs_pkg::PWR_OFF;
        endcase
    end

    // Register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwrState_q <= bbs_pkg::PWR_OFF;
            recCnt_q   <= 32'h0000_0000;
        end
        else
        begin
            pwrState_q <= pwrState_d;
            recCnt_q   <= recCnt_d;
        end
    end

    // ------------------------------------------------------------
    // Bus decode and access ages
    // ------------------------------------------------------------
    logic        selIn;
    logic        rdMode;
    logic        wrMode;
    logic        wrMode_q;
    logic [14:0] prevAddr_q;
    logic [3:0]  addrAge_q;
    logic [3:0]  selAge_q;
    logic [3:0]  drvAge_q;
    logic [3:0]  stbAge_q;
    logic [3:0]  addrAge_d;
    logic [3:0]  selAge_d;
    logic [3:0]  drvAge_d;
    logic [3:0]  stbAge_d;

    // Power fail ignores every control pin
    assign selIn  = busOn & ~pinsSync_q.sel_n;
    assign rdMode = selIn & pinsSync_q.stb_n;
    assign wrMode = selIn & ~pinsSync_q.stb_n;

    // Ages saturate; each restarts on its own cause
    always_comb
    begin
        addrAge_d = (addrAge_q == 4'hF) ? addrAge_q : addrAge_q + 4'h1;
        selAge_d  = (selAge_q == 4'hF) ? selAge_q : selAge_q + 4'h1;
        drvAge_d  = (drvAge_q == 4'hF) ? drvAge_q : drvAge_q + 4'h1;
        stbAge_d  = (stbAge_q == 4'hF) ? stbAge_q : stbAge_q + 4'h1;
        if (pinsSync_q.addr != prevAddr_q)
            addrAge_d = 4'h0;
        if (!selIn)
            selAge_d = 4'h0;
        if (pinsSync_q.drv_n)
            drvAge_d = 4'h0;
        if (pinsSync_q.stb_n)
            stbAge_d = 4'h0;
    end

    // Register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prevAddr_q <= 15'h0000;
            addrAge_q  <= 4'h0;
            selAge_q   <= 4'h0;
            drvAge_q   <= 4'h0;
            stbAge_q   <= 4'h0;
            wrMode_q   <= 1'b0;
        end
        else
        begin
            prevAddr_q <= pinsSync_q.addr;
            addrAge_q  <= addrAge_d;
            selAge_q   <= selAge_d;
            drvAge_q   <= drvAge_d;
            stbAge_q   <= stbAge_d;
            wrMode_q   <= wrMode;
        end
    end

    // ------------------------------------------------------------
    // Storage array and write commit
    // ------------------------------------------------------------
    logic [7:0]  memArr [`BBS_MEM_DEPTH];
    logic [7:0]  memRd_q;
    logic [14:0] wrAddr_q;
    logic [7:0]  wrData_q;
    logic        commit;
    logic        commitRtc;
    logic        isRtc;

    // Top eight addresses divert to the clock cells
    assign isRtc     = pinsSync_q.addr >= `BBS_RTC_BASE;
    // Commit at the earlier rising edge, never while power fails
    assign commit    = wrMode_q & ~wrMode & busOn;
    assign commitRtc = commit & (wrAddr_q >= `BBS_RTC_BASE);

    // Latest address and data while the write is open
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrAddr_q <= 15'h0000;
            wrData_q <= 8'h00;
        end
        else if (wrMode)
        begin
            wrAddr_q <= pinsSync_q.addr;
            wrData_q <= pinsSync_q.data;
        end
    end

    // Array has no reset; contents survive battery mode
    always_ff @(posedge core_clk)
    begin
        if (commit && !commitRtc)
            memArr[wrAddr_q] <= wrData_q;
        memRd_q <= memArr[pinsSync_q.addr];
    end

    // ------------------------------------------------------------
    // Clock counters
    // ------------------------------------------------------------
    logic [31:0] secCnt_q;
    logic [31:0] secCnt_d;
    logic        secTick;
    logic        copy_q;
    logic [7:0]  rtcByte_q [8];
    logic [7:0]  rtcByte_d [8];
    logic [7:0]  cntVal [8];
    logic [7:0]  cntMax [8];
    logic [7:0]  wrapVec;
    logic [7:0]  stepVec;
    logic        loadCnt;
    logic        leapYear;
    logic [7:0]  maxDay;

    // Counting never stops, also on battery
    assign secTick = secCnt_q >= 32'(SEC_CYC - 1);
    assign secCnt_d = secTick ? 32'h0000_0000 : secCnt_q + 32'h0000_0001;

    // BCD leap year: tens even with units 0/4/8, or tens odd with 2/6
    assign leapYear = cntVal[7][4] ? (cntVal[7][3:0] == 4'h2 ||
                                      cntVal[7][3:0] == 4'h6)
                                   : (cntVal[7][1:0] == 2'h0);

    // Month lengths
    always_comb
    begin
        unique case (cntVal[6])
            8'h02:   maxDay = leapYear ? 8'h29 : 8'h28;
            8'h04,
            8'h06,
            8'h09,
            8'h11:   maxDay = 8'h30;
            default: maxDay = 8'h31;
        endcase
    end

    // Carry chain from seconds to years
    assign stepVec = {wrapVec[6], wrapVec[5], wrapVec[3], wrapVec[3],
                      wrapVec[2], wrapVec[1], secTick, 1'b0};
    assign cntMax  = '{8'h00, 8'h59, 8'h59, 8'h23, 8'h07,
                       maxDay, 8'h12, 8'h99};
    localparam logic [7:0] CNT_MIN [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
                                          8'h01, 8'h01, 8'h00};
    assign cntVal[0] = 8'h00;
    assign wrapVec[0] = 1'b0;

    // One BCD counter per time field
    for (genvar i = 1; i < 8; i++)
    begin : g_cnt
        bbs_bcd_count #(
            .MIN_VAL (CNT_MIN[i])
        ) u_cnt (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .step     (stepVec[i]),
            .load     (loadCnt),
            .loadVal  (rtcByte_q[i]),
            .maxVal   (cntMax[i]),
            .count_q  (cntVal[i]),
            .wrap     (wrapVec[i])
        );
    end

    // ------------------------------------------------------------
    // Clock cells and control byte
    // ------------------------------------------------------------
    logic [7:0] ctrl;
    logic       frozen;

    assign ctrl    = rtcByte_q[`BBS_CTRL_IDX];
    // Either access bit stops the refresh so the host sees a still time
    assign frozen  = ctrl[`BBS_CTL_WRITE] | ctrl[`BBS_CTL_READ];
    // Clearing the write bit loads the host's time into the counters
    assign loadCnt = commitRtc && wrAddr_q[2:0] == `BBS_CTRL_IDX &&
                     ctrl[`BBS_CTL_WRITE] && !wrData_q[`BBS_CTL_WRITE];

    // Refresh once a second; a host write on the same cycle wins
    always_comb
    begin
        rtcByte_d = rtcByte_q;
        if (copy_q && !frozen)
        begin
            for (int k = 1; k < 8; k++)
                rtcByte_d[k] = cntVal[k];
        end
        if (commitRtc)
            rtcByte_d[wrAddr_q[2:0]] = wrData_q;
    end

    // Register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            secCnt_q  <= 32'h0000_0000;
            copy_q    <= 1'b0;
            rtcByte_q <= '{default: `BBS_CTL_RST};
        end
        else
        begin
            secCnt_q  <= secCnt_d;
            copy_q    <= secTick;
            rtcByte_q <= rtcByte_d;
        end
    end

    // ------------------------------------------------------------
    // Read path and output drive
    // ------------------------------------------------------------
    logic       oeNow;
    logic       accessOk;
    logic       holdOld;
    logic       dataValid_q;
    logic       dataValid_d;
    logic [7:0] readByte;
    logic [7:0] dataOut_d;

    // Strobe falling keeps the drive only FLOAT_CYC cycles
    assign oeNow    = selIn & ~pinsSync_q.drv_n &
                      (pinsSync_q.stb_n | stbAge_q < 4'(FLOAT_CYC));
    assign accessOk = addrAge_q >= 4'(ADDR_CYC) &&
                      selAge_q >= 4'(SEL_CYC) &&
                      drvAge_q >= 4'(DRV_CYC);
    assign holdOld  = dataValid_q && addrAge_q < 4'(HOLD_CYC);
    assign readByte = isRtc ? rtcByte_q[pinsSync_q.addr[2:0]] : memRd_q;

    // Old byte holds briefly, then a fixed junk pattern until valid
    always_comb
    begin
        dataOut_d   = `BBS_UNDEF_DATA;
        dataValid_d = 1'b0;
        if (!oeNow)
            dataOut_d = dataLinesOut;
        else if (holdOld)
        begin
            dataOut_d   = dataLinesOut;
            dataValid_d = 1'b1;
        end
        else if (rdMode && accessOk)
        begin
            dataOut_d   = readByte;
            dataValid_d = 1'b1;
        end
    end

    // Register
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dataLinesOut <= 8'h00;
            dataLinesOe  <= 1'b0;
            dataValid_q  <= 1'b0;
        end
        else
        begin
            dataLinesOut <= dataOut_d;
            dataLinesOe  <= oeNow;
            dataValid_q  <= dataValid_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence stbFall_s;
        $fell(pinsSync_q.stb_n) ##1 !pinsSync_q.stb_n;
    endsequence

    sequence wrEnd_s;
        wrMode ##1 (!wrMode && busOn);
    endsequence

    oe_gated_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        dataLinesOe |-> $past(selIn && !pinsSync_q.drv_n))
        else $error("Data lines driven without select and drive");
    off_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pwrState_q != bbs_pkg::PWR_ON) |=> !dataLinesOe)
        else $error("Data lines driven during power fail");
    rec_ignore_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pwrState_q == bbs_pkg::PWR_REC) [*2] |-> !dataLinesOe && !commit)
        else $error("Bus acted during recovery");
    early_undef_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (oeNow && !accessOk && !holdOld) |=> dataLinesOut == `BBS_UNDEF_DATA)
        else $error("Data shown before access time");
    read_data_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (oeNow && rdMode && accessOk && !holdOld) |=> dataLinesOut == $past(readByte))
        else $error("Read data wrong after access time");
    hold_old_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (oeNow && holdOld) |=> $stable(dataLinesOut))
        else $error("Old data not held after address change");
    strobe_float_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        stbFall_s |=> !dataLinesOe)
        else $error("Outputs still driven after strobe fell");
    write_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wrEnd_s ##0 (wrAddr_q < `BBS_RTC_BASE) |=> memArr[$past(wrAddr_q)] == $past(wrData_q))
        else $error("Write not stored at its end");
    month_roll_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (stepVec[5] && !loadCnt && cntVal[5] >= maxDay) |=> cntVal[5] == 8'h01)
        else $error("Date did not roll at month end");
    copy_sec_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (copy_q && !frozen && !commitRtc) |=> rtcByte_q[1] == $past(cntVal[1]))
        else $error("Seconds byte not refreshed");

endmodule // bbs_sram_rtc
